/* File: hdl/tdc_aux_rate.sv */
// rate lookup for one auxiliary digital clock output
`timescale 1ns/1ps
`default_nettype none
module tdc_aux_rate (
  // selection
  input  wire logic        familySel,
  input  wire logic [1:0]  rateCode,
  // result
  output logic [14:0]      rateKhz
);

  // purely combinational; the caller registers the result
  always_comb begin
    case ({familySel, rateCode})
      3'h4:    rateKhz = tdc_pkg::KHZ_SON_0;  // (R1)
      3'h5:    rateKhz = tdc_pkg::KHZ_SON_1;
      3'h6:    rateKhz = tdc_pkg::KHZ_SON_2;
      3'h7:    rateKhz = tdc_pkg::KHZ_SON_3;
      3'h0:    rateKhz = tdc_pkg::KHZ_SDH_0;  // (R2)
      3'h1:    rateKhz = tdc_pkg::KHZ_SDH_1;
      3'h2:    rateKhz = tdc_pkg::KHZ_SDH_2;
      default: rateKhz = tdc_pkg::KHZ_SDH_3;
    endcase
  end

endmodule : tdc_aux_rate
`default_nettype wire

/* File: hdl/tdc_config_regs.sv */
// configuration register bank of the timing loop, on the processor port
`timescale 1ns/1ps
`default_nettype none

// Function
// (R1) per-output family bit: 1 sonet, 0 sdh
// (R2) two-bit rate code per auxiliary output
// (R3) two-bit differential level: off, pecl, lvds
// (R4) auto loop bandwidth or always locked
// (R5) freeze integrator at frequency limits
// (R6) 16-bit unsigned crystal trim, default zero (here both bytes reset to 0x99, so the trim comes up as 0x9999)
// (R7) 19-bit signed manual holdover value
// (R8) 10-bit unsigned symmetric pull-in limit
// (R9) holdover averaging, readback and mini-holdover controls
module tdc_config_regs (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // microprocessor port
  input  wire logic [7:0]  upAddr,
  input  wire logic        upWrEn,
  input  wire logic [7:0]  upWrData,
  input  wire logic        upRdEn,
  output logic [7:0]       upRdData,
  output logic             upRdValid,
  // averaged holdover value from the loop core
  input  wire logic [18:0] avgHoldValue,
  // auxiliary digital outputs
  output logic             aux_a_family_sel,
  output logic             aux_b_family_sel,
  output logic [1:0]       aux_a_rate_code,
  output logic [1:0]       aux_b_rate_code,
  output logic [14:0]      auxARateKhz,
  output logic [14:0]      auxBRateKhz,
  // differential outputs
  output logic [1:0]       diff_out_a_level,
  output logic [1:0]       diff_out_b_level,
  output logic             diffOutAEnable,
  output logic             diffOutBEnable,
  output logic             diffOutALvds,
  output logic             diffOutBLvds,
  // main loop controls
  output logic             auto_loop_bw,
  output logic             integrator_limit_freeze,
  output logic [15:0]      crystalTrim,
  output logic [18:0]      manualHoldValue,
  output logic             holdAutoAverage,
  output logic             holdFastAverage,
  output logic             holdReadAverage,
  output logic [1:0]       miniHoldMode,
  output logic [9:0]       pull_range_value
);

  // storage: one byte per register, indexed from the first offset
  logic [7:0] regFile_q [tdc_pkg::NUM_REGS];

  // rate lookups before registering
  logic [14:0] auxARateKhz_d;
  logic [14:0] auxBRateKhz_d;

  // offset to storage index; used by both write and read paths
  function automatic logic [3:0] regIndex(input logic [7:0] addr);
    case (addr)
      tdc_pkg::OFS_FAMILY:   regIndex = tdc_pkg::IDX_FAMILY;
      tdc_pkg::OFS_RATES:    regIndex = tdc_pkg::IDX_RATES;
      tdc_pkg::OFS_LEVELS:   regIndex = tdc_pkg::IDX_LEVELS;
      tdc_pkg::OFS_LOOPBW:   regIndex = tdc_pkg::IDX_LOOPBW;
      tdc_pkg::OFS_TRIM_LO:  regIndex = tdc_pkg::IDX_TRIM_LO;
      tdc_pkg::OFS_TRIM_HI:  regIndex = tdc_pkg::IDX_TRIM_HI;
      tdc_pkg::OFS_HOLD_LO:  regIndex = tdc_pkg::IDX_HOLD_LO;
      tdc_pkg::OFS_HOLD_MID: regIndex = tdc_pkg::IDX_HOLD_MID;
      tdc_pkg::OFS_HOLD_CTL: regIndex = tdc_pkg::IDX_HOLD_CTL;
      tdc_pkg::OFS_PULL_LO:  regIndex = tdc_pkg::IDX_PULL_LO;
      tdc_pkg::OFS_PULL_HI:  regIndex = tdc_pkg::IDX_PULL_HI;
      default:               regIndex = tdc_pkg::IDX_NONE;
    endcase
  endfunction : regIndex

  // reset value for each storage index
  function automatic logic [7:0] resetValue(input logic [3:0] idx);
    case (idx)
      tdc_pkg::IDX_FAMILY:   resetValue = tdc_pkg::RST_FAMILY;
      tdc_pkg::IDX_RATES:    resetValue = tdc_pkg::RST_RATES;
      tdc_pkg::IDX_LEVELS:   resetValue = tdc_pkg::RST_LEVELS;
      tdc_pkg::IDX_LOOPBW:   resetValue = tdc_pkg::RST_LOOPBW;
      tdc_pkg::IDX_TRIM_LO:  resetValue = tdc_pkg::RST_TRIM_LO;
      tdc_pkg::IDX_TRIM_HI:  resetValue = tdc_pkg::RST_TRIM_HI;
      tdc_pkg::IDX_HOLD_LO:  resetValue = tdc_pkg::RST_HOLD_LO;
      tdc_pkg::IDX_HOLD_MID: resetValue = tdc_pkg::RST_HOLD_MID;
      tdc_pkg::IDX_HOLD_CTL: resetValue = tdc_pkg::RST_HOLD_CTL;
      tdc_pkg::IDX_PULL_LO:  resetValue = tdc_pkg::RST_PULL_LO;
      default:               resetValue = tdc_pkg::RST_PULL_HI;
    endcase
  endfunction : resetValue

  // write path: each byte loads on a write to its own offset
  // unused bits are stored too, so readback matches the reset image
  for (genvar gi = 0; gi < tdc_pkg::NUM_REGS; gi++) begin : g_reg
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        regFile_q[gi] <= resetValue(4'(gi));
      end else if (upWrEn && regIndex(upAddr) == 4'(gi)) begin
        regFile_q[gi] <= upWrData;
      end
    end
  end

  // read path: registered data one cycle after the strobe
  // holdover bytes may show the averaged value instead of the written one
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      upRdData  <= 8'h00;
      upRdValid <= 1'b0;
    end else begin
      upRdValid <= upRdEn;
      if (!upRdEn) begin
        // hold last data between reads
        upRdData <= upRdData;
      end else if (regIndex(upAddr) == tdc_pkg::IDX_NONE) begin
        // unmapped offset reads as zero
        upRdData <= 8'h00;
      end else if (holdReadAverage &&
                   regIndex(upAddr) == tdc_pkg::IDX_HOLD_LO) begin
        upRdData <= avgHoldValue[7:0];  // (R9)
      end else if (holdReadAverage &&
                   regIndex(upAddr) == tdc_pkg::IDX_HOLD_MID) begin
        upRdData <= avgHoldValue[15:8];  // (R9)
      end else if (holdReadAverage &&
                   regIndex(upAddr) == tdc_pkg::IDX_HOLD_CTL) begin
        // control bits stay as written, only the value field swaps
        upRdData <= {regFile_q[tdc_pkg::IDX_HOLD_CTL][7:3],
                     avgHoldValue[18:16]};  // (R9)
      end else begin
        upRdData <= regFile_q[regIndex(upAddr)];
      end
    end
  end

  // rate lookup per auxiliary output
  tdc_aux_rate u_rate_a (
    .familySel (regFile_q[tdc_pkg::IDX_FAMILY][tdc_pkg::BIT_FAM_A]),
    .rateCode  (regFile_q[tdc_pkg::IDX_RATES][tdc_pkg::RATE_A_LSB +: 2]),
    .rateKhz   (auxARateKhz_d)
  );

  tdc_aux_rate u_rate_b (
    .familySel (regFile_q[tdc_pkg::IDX_FAMILY][tdc_pkg::BIT_FAM_B]),
    .rateCode  (regFile_q[tdc_pkg::IDX_RATES][tdc_pkg::RATE_B_LSB +: 2]),
    .rateKhz   (auxBRateKhz_d)
  );

  // auxiliary clock configuration outputs, one cycle behind the bytes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      aux_a_family_sel <= 1'b0;
      aux_b_family_sel <= 1'b0;
      aux_a_rate_code  <= 2'h0;
      aux_b_rate_code  <= 2'h0;
      auxARateKhz      <= tdc_pkg::KHZ_SDH_0;
      auxBRateKhz      <= tdc_pkg::KHZ_SDH_0;
    end else begin
      aux_a_family_sel <= regFile_q[tdc_pkg::IDX_FAMILY]
                                   [tdc_pkg::BIT_FAM_A];  // (R1)
      aux_b_family_sel <= regFile_q[tdc_pkg::IDX_FAMILY]
                                   [tdc_pkg::BIT_FAM_B];  // (R1)
      aux_a_rate_code  <= regFile_q[tdc_pkg::IDX_RATES]
                                   [tdc_pkg::RATE_A_LSB +: 2];  // (R2)
      aux_b_rate_code  <= regFile_q[tdc_pkg::IDX_RATES]
                                   [tdc_pkg::RATE_B_LSB +: 2];  // (R2)
      auxARateKhz      <= auxARateKhz_d;  // (R2)
      auxBRateKhz      <= auxBRateKhz_d;  // (R2)
    end
  end

  // differential outputs; the spare code 11 clears enable and lvds (the level
  // output still carries 11) so a bad write can never drive an undefined standard onto the pins
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      diff_out_a_level <= 2'h0;
      diff_out_b_level <= 2'h0;
      diffOutAEnable   <= 1'b0;
      diffOutBEnable   <= 1'b0;
      diffOutALvds     <= 1'b0;
      diffOutBLvds     <= 1'b0;
    end else begin
      diff_out_a_level <= regFile_q[tdc_pkg::IDX_LEVELS]
                                   [tdc_pkg::LEVEL_A_LSB +: 2];  // (R3)
      diff_out_b_level <= regFile_q[tdc_pkg::IDX_LEVELS]
                                   [tdc_pkg::LEVEL_B_LSB +: 2];  // (R3)
      diffOutAEnable <= (regFile_q[tdc_pkg::IDX_LEVELS]
                          [tdc_pkg::LEVEL_A_LSB +: 2] == tdc_pkg::LEVEL_PECL)
                     || (regFile_q[tdc_pkg::IDX_LEVELS]
                          [tdc_pkg::LEVEL_A_LSB +: 2] == tdc_pkg::LEVEL_LVDS);
      diffOutBEnable <= (regFile_q[tdc_pkg::IDX_LEVELS]
                          [tdc_pkg::LEVEL_B_LSB +: 2] == tdc_pkg::LEVEL_PECL)
                     || (regFile_q[tdc_pkg::IDX_LEVELS]
                          [tdc_pkg::LEVEL_B_LSB +: 2] == tdc_pkg::LEVEL_LVDS);
      diffOutALvds <= regFile_q[tdc_pkg::IDX_LEVELS]
                        [tdc_pkg::LEVEL_A_LSB +: 2] == tdc_pkg::LEVEL_LVDS;
      diffOutBLvds <= regFile_q[tdc_pkg::IDX_LEVELS]
                        [tdc_pkg::LEVEL_B_LSB +: 2] == tdc_pkg::LEVEL_LVDS;
    end
  end

  // loop bandwidth and integrator controls
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      auto_loop_bw            <= 1'b0;
      integrator_limit_freeze <= 1'b0;
    end else begin
      auto_loop_bw <= regFile_q[tdc_pkg::IDX_LOOPBW]
                               [tdc_pkg::BIT_AUTO_BW];  // (R4)
      integrator_limit_freeze <= regFile_q[tdc_pkg::IDX_LOOPBW]
                                          [tdc_pkg::BIT_LIM_INT];  // (R5)
    end
  end

  // assembled multi-byte values; software should write low bytes first,
  // since each byte takes effect on its own
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      crystalTrim      <= 16'h0000;
      manualHoldValue  <= 19'h00000;
      pull_range_value <= 10'h000;
    end else begin
      // unsigned trim; only the loop sees it, monitors stay uncalibrated
      crystalTrim <= {regFile_q[tdc_pkg::IDX_TRIM_HI],
                      regFile_q[tdc_pkg::IDX_TRIM_LO]};  // (R6)
      // two's complement, sign in bit 18
      manualHoldValue <= {regFile_q[tdc_pkg::IDX_HOLD_CTL]
                                   [tdc_pkg::HOLD_TOP_W-1:0],
                          regFile_q[tdc_pkg::IDX_HOLD_MID],
                          regFile_q[tdc_pkg::IDX_HOLD_LO]};  // (R7)
      // magnitude, applied to both signs by the loop
      pull_range_value <= {regFile_q[tdc_pkg::IDX_PULL_HI]
                                    [tdc_pkg::PULL_TOP_W-1:0],
                           regFile_q[tdc_pkg::IDX_PULL_LO]};  // (R8)
    end
  end

  // holdover mode controls
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      holdAutoAverage <= 1'b0;
      holdFastAverage <= 1'b0;
      holdReadAverage <= 1'b0;
      miniHoldMode    <= 2'h0;
    end else begin
      holdAutoAverage <= regFile_q[tdc_pkg::IDX_HOLD_CTL]
                                  [tdc_pkg::BIT_AUTO_AVG];  // (R9)
      holdFastAverage <= regFile_q[tdc_pkg::IDX_HOLD_CTL]
                                  [tdc_pkg::BIT_FAST_AVG];  // (R9)
      holdReadAverage <= regFile_q[tdc_pkg::IDX_HOLD_CTL]
                                  [tdc_pkg::BIT_READ_AVG];  // (R9)
      miniHoldMode    <= regFile_q[tdc_pkg::IDX_HOLD_CTL]
                                  [tdc_pkg::MINI_HOLD_LSB +: 2];  // (R9)
    end
  end

endmodule : tdc_config_regs
`default_nettype wire

/* File: hdl/tdc_pkg.sv */
// package with register map, field layout and reset values of the bank
package tdc_pkg;

  // port widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned KHZ_W  = 15;

  // register offsets on the microprocessor port
  localparam logic [7:0] OFS_FAMILY   = 8'h38;
  localparam logic [7:0] OFS_RATES    = 8'h39;
  localparam logic [7:0] OFS_LEVELS   = 8'h3a;
  localparam logic [7:0] OFS_LOOPBW   = 8'h3b;
  localparam logic [7:0] OFS_TRIM_LO  = 8'h3c;
  localparam logic [7:0] OFS_TRIM_HI  = 8'h3d;
  localparam logic [7:0] OFS_HOLD_LO  = 8'h3e;
  localparam logic [7:0] OFS_HOLD_MID = 8'h3f;
  localparam logic [7:0] OFS_HOLD_CTL = 8'h40;
  localparam logic [7:0] OFS_PULL_LO  = 8'h41;
  localparam logic [7:0] OFS_PULL_HI  = 8'h42;

  // register file indexing: index = offset - first offset
  localparam int unsigned NUM_REGS = 11;
  localparam logic [3:0] IDX_FAMILY   = 4'h0;
  localparam logic [3:0] IDX_RATES    = 4'h1;
  localparam logic [3:0] IDX_LEVELS   = 4'h2;
  localparam logic [3:0] IDX_LOOPBW   = 4'h3;
  localparam logic [3:0] IDX_TRIM_LO  = 4'h4;
  localparam logic [3:0] IDX_TRIM_HI  = 4'h5;
  localparam logic [3:0] IDX_HOLD_LO  = 4'h6;
  localparam logic [3:0] IDX_HOLD_MID = 4'h7;
  localparam logic [3:0] IDX_HOLD_CTL = 4'h8;
  localparam logic [3:0] IDX_PULL_LO  = 4'h9;
  localparam logic [3:0] IDX_PULL_HI  = 4'ha;
  localparam logic [3:0] IDX_NONE     = 4'hf;

  // reset values
  localparam logic [7:0] RST_FAMILY   = 8'h00;
  localparam logic [7:0] RST_RATES    = 8'h08;
  localparam logic [7:0] RST_LEVELS   = 8'hc6;
  localparam logic [7:0] RST_LOOPBW   = 8'hfb;
  localparam logic [7:0] RST_TRIM_LO  = 8'h99;
  localparam logic [7:0] RST_TRIM_HI  = 8'h99;
  localparam logic [7:0] RST_HOLD_LO  = 8'h00;
  localparam logic [7:0] RST_HOLD_MID = 8'h00;
  localparam logic [7:0] RST_HOLD_CTL = 8'h88;
  localparam logic [7:0] RST_PULL_LO  = 8'h76;
  localparam logic [7:0] RST_PULL_HI  = 8'h00;

  // field positions
  localparam int unsigned BIT_FAM_B      = 6;
  localparam int unsigned BIT_FAM_A      = 5;
  localparam int unsigned RATE_B_LSB     = 6;
  localparam int unsigned RATE_A_LSB     = 4;
  localparam int unsigned LEVEL_B_LSB    = 2;
  localparam int unsigned LEVEL_A_LSB    = 0;
  localparam int unsigned BIT_AUTO_BW    = 7;
  localparam int unsigned BIT_LIM_INT    = 3;
  localparam int unsigned BIT_AUTO_AVG   = 7;
  localparam int unsigned BIT_FAST_AVG   = 6;
  localparam int unsigned BIT_READ_AVG   = 5;
  localparam int unsigned MINI_HOLD_LSB  = 3;
  localparam int unsigned HOLD_TOP_W     = 3;
  localparam int unsigned PULL_TOP_W     = 2;

  // differential level codes
  localparam logic [1:0] LEVEL_OFF  = 2'h0;
  localparam logic [1:0] LEVEL_PECL = 2'h1;
  localparam logic [1:0] LEVEL_LVDS = 2'h2;

  // auxiliary output rates in kHz, sonet family then sdh family
  localparam logic [14:0] KHZ_SON_0 = 15'd1544;
  localparam logic [14:0] KHZ_SON_1 = 15'd3088;
  localparam logic [14:0] KHZ_SON_2 = 15'd6176;
  localparam logic [14:0] KHZ_SON_3 = 15'd12352;
  localparam logic [14:0] KHZ_SDH_0 = 15'd2048;
  localparam logic [14:0] KHZ_SDH_1 = 15'd4096;
  localparam logic [14:0] KHZ_SDH_2 = 15'd8192;
  localparam logic [14:0] KHZ_SDH_3 = 15'd16384;

endpackage : tdc_pkg

/* File: test/tdc_config_regs_chk.sv */
// concurrent checks on the ports of the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tdc_config_regs_chk (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // processor port
  input wire logic [7:0]  upAddr,
  input wire logic        upWrEn,
  input wire logic [7:0]  upWrData,
  input wire logic        upRdEn,
  input wire logic        upRdValid,
  // auxiliary outputs
  input wire logic        aux_a_family_sel,
  input wire logic        aux_b_family_sel,
  input wire logic [1:0]  aux_a_rate_code,
  input wire logic [1:0]  aux_b_rate_code,
  input wire logic [14:0] auxARateKhz,
  input wire logic [14:0] auxBRateKhz,
  // differential outputs
  input wire logic [1:0]  diff_out_a_level,
  input wire logic [1:0]  diff_out_b_level,
  input wire logic        diffOutAEnable,
  input wire logic        diffOutBEnable,
  input wire logic        diffOutALvds,
  input wire logic        diffOutBLvds,
  // loop controls
  input wire logic        auto_loop_bw,
  input wire logic        integrator_limit_freeze,
  input wire logic [15:0] crystalTrim,
  input wire logic [18:0] manualHoldValue,
  input wire logic [1:0]  miniHoldMode,
  input wire logic [9:0]  pull_range_value
);
  // one clock domain, so clocking and reset are given once
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // rate in khz: each code step doubles the family's base rate
  function automatic logic [14:0] rateOf(input logic fam,
                                         input logic [1:0] code);
    rateOf = (fam ? 15'd1544 : 15'd2048) << code;
  endfunction : rateOf

  // a write strobe aimed at one offset
  sequence wrTo(logic [7:0] ofs);
    upWrEn && upAddr == ofs;
  endsequence

  AST_RATE_A:
    assert property (auxARateKhz == rateOf(aux_a_family_sel, aux_a_rate_code))
    else $error("aux a rate does not match family and code");
  AST_RATE_B:
    assert property (auxBRateKhz == rateOf(aux_b_family_sel, aux_b_rate_code))
    else $error("aux b rate does not match family and code");
  AST_LVL_A:
    assert property (diffOutAEnable == (diff_out_a_level inside {2'h1, 2'h2})
      && diffOutALvds == (diff_out_a_level == 2'h2))
    else $error("diff a enable or lvds wrong for level");
  AST_LVL_B:
    assert property (diffOutBEnable == (diff_out_b_level inside {2'h1, 2'h2})
      && diffOutBLvds == (diff_out_b_level == 2'h2))
    else $error("diff b enable or lvds wrong for level");
  AST_LOOP_BW:
    assert property (wrTo(tdc_pkg::OFS_LOOPBW) |-> ##2
      auto_loop_bw == $past(upWrData[7], 2)
      && integrator_limit_freeze == $past(upWrData[3], 2))
    else $error("loop bandwidth controls not taken from write");
  AST_TRIM_LO:
    assert property (wrTo(tdc_pkg::OFS_TRIM_LO) |-> ##2
      crystalTrim[7:0] == $past(upWrData, 2))
    else $error("crystal trim low byte not taken from write");
  AST_HOLD_CTL:
    assert property (wrTo(tdc_pkg::OFS_HOLD_CTL) |-> ##2
      manualHoldValue[18:16] == $past(upWrData[2:0], 2)
      && miniHoldMode == $past(upWrData[4:3], 2))
    else $error("holdover top bits or mini mode not taken");
  AST_PULL_HI:
    assert property (wrTo(tdc_pkg::OFS_PULL_HI) |-> ##2
      pull_range_value[9:8] == $past(upWrData[1:0], 2))
    else $error("pull range top bits not taken from write");
  AST_RD_VALID:
    assert property (1'b1 |=> upRdValid == $past(upRdEn))
    else $error("read valid not exactly one cycle after strobe");
endmodule : tdc_config_regs_chk

bind tdc_config_regs tdc_config_regs_chk tdc_config_regs_chk_i (.*);
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // design ports
  logic        core_clk, rst_n, upWrEn, upRdEn, upRdValid;
  logic [7:0]  upAddr, upWrData, upRdData;
  logic [18:0] avgHoldValue, manualHoldValue;
  logic        aux_a_family_sel, aux_b_family_sel, auto_loop_bw;
  logic [1:0]  aux_a_rate_code, aux_b_rate_code, miniHoldMode;
  logic [14:0] auxARateKhz, auxBRateKhz;
  logic [1:0]  diff_out_a_level, diff_out_b_level;
  logic        diffOutAEnable, diffOutBEnable, diffOutALvds, diffOutBLvds;
  logic        integrator_limit_freeze, holdAutoAverage;
  logic        holdFastAverage, holdReadAverage;
  logic [15:0] crystalTrim;
  logic [9:0]  pull_range_value;
  // counters
  int          n_fail;
  int          checks_done;
  // reset images of offsets 0x38 to 0x42
  logic [7:0]  rstImg [0:10] = '{8'h00, 8'h08, 8'hc6, 8'hfb, 8'h99,
    8'h99, 8'h00, 8'h00, 8'h88, 8'h76, 8'h00};

  tdc_config_regs tdc_config_regs_i (.*);

  // 200 mhz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // compare one register byte
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_byte

  // compare a decoded output, zero extended
  task automatic cmp_out(input logic [18:0] got, input logic [18:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_out

  // write, then wait until decoded outputs have followed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    upAddr = a;
    upWrData = d;
    upWrEn = 1'b1;
    @(negedge core_clk);
    upWrEn = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask : wr

  // read: answer stands exactly one cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    upAddr = a;
    upRdEn = 1'b1;
    @(negedge core_clk);
    upRdEn = 1'b0;
    cmp_byte({7'h0, upRdValid}, 8'h01);
    cmp_byte(upRdData, exp);
  endtask : rd

  // expected aux rate: base of the family doubled per code step
  function automatic logic [18:0] rate(input logic son, input int code);
    rate = (son ? 19'd1544 : 19'd2048) << code;
  endfunction : rate

  task automatic end_test(input string name);
    $display("test %s finished", name);
  endtask : end_test

  // single exit point of the run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  // hang guard, counted as a mismatch
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end

  // main sequence
  initial begin
    n_fail = 0;
    checks_done = 0;
    rst_n = 1'b0;
    upWrEn = 1'b0;
    upRdEn = 1'b0;
    upAddr = 8'h00;
    upWrData = 8'h00;
    avgHoldValue = 19'h2c3f1;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    // defaults of every register and of the trim, pull range, loop, aux a rate, level and holdover control outputs
    for (int i = 0; i < 11; i++)
      rd(8'h38 + 8'(i), rstImg[i]);
    cmp_out(19'(crystalTrim), 19'h09999);
    cmp_out(19'(pull_range_value), 19'h00076);
    cmp_out({17'h0, auto_loop_bw, integrator_limit_freeze}, 19'h3);
    cmp_out(19'(auxARateKhz), 19'd2048);
    cmp_out({15'h0, diff_out_b_level, diff_out_a_level}, 19'h6);
    cmp_out({14'h0, holdAutoAverage, holdFastAverage, holdReadAverage,
      miniHoldMode}, 19'h11);
    end_test("reset");
    // every family and rate code on both aux outputs
    for (int f = 0; f < 4; f++) begin
      for (int c = 0; c < 4; c++) begin
        wr(8'h38, {1'b0, 2'(f), 5'h0});
        wr(8'h39, {2'(3 - c), 2'(c), 4'h0});
        cmp_out(19'(auxARateKhz), rate(f[0], c));
        cmp_out(19'(auxBRateKhz), rate(f[1], 3 - c));
        cmp_out({13'h0, aux_b_family_sel, aux_a_family_sel, aux_b_rate_code,
          aux_a_rate_code}, {13'h0, 2'(f), 2'(3 - c), 2'(c)});
      end
    end
    end_test("aux rates");
    // every level code, code 11 reads as disabled
    for (int c = 0; c < 4; c++) begin
      wr(8'h3a, {4'h0, 2'(3 - c), 2'(c)});
      cmp_out({15'h0, diff_out_b_level, diff_out_a_level},
        19'(4 * (3 - c) + c));
      cmp_out({15'h0, diffOutAEnable, diffOutALvds, diffOutBEnable,
        diffOutBLvds}, {15'h0, c == 1 || c == 2, c == 2, c == 1 || c == 2,
        c == 1});
    end
    end_test("levels");
    // bandwidth select and integrator freeze move independently
    wr(8'h3b, 8'h08);
    cmp_out({17'h0, auto_loop_bw, integrator_limit_freeze}, 19'h1);
    wr(8'h3b, 8'h80);
    cmp_out({17'h0, auto_loop_bw, integrator_limit_freeze}, 19'h2);
    end_test("loop bandwidth");
    // trim assembled from two bytes
    wr(8'h3c, 8'h34);
    wr(8'h3d, 8'h12);
    cmp_out(19'(crystalTrim), 19'h01234);
    rd(8'h3c, 8'h34);
    end_test("trim");
    // holdover value, controls and averaged readback
    wr(8'h3e, 8'ha5);
    wr(8'h3f, 8'h5a);
    wr(8'h40, 8'h95);
    cmp_out(manualHoldValue, 19'h55aa5);
    cmp_out({14'h0, holdAutoAverage, holdFastAverage, holdReadAverage,
      miniHoldMode}, 19'h12);
    wr(8'h40, 8'h63);
    cmp_out(manualHoldValue, 19'h35aa5);
    cmp_out({14'h0, holdAutoAverage, holdFastAverage, holdReadAverage,
      miniHoldMode}, 19'h0c);
    rd(8'h3e, 8'hf1);
    rd(8'h3f, 8'hc3);
    rd(8'h40, 8'h62);
    wr(8'h40, 8'h08);
    rd(8'h3e, 8'ha5);
    end_test("holdover");
    // pull range uses only two bits of the top byte
    wr(8'h41, 8'hff);
    wr(8'h42, 8'hfe);
    cmp_out(19'(pull_range_value), 19'h002ff);
    end_test("pull range");
    // unmapped offsets ignore writes and read as zero
    wr(8'h43, 8'hff);
    rd(8'h43, 8'h00);
    rd(8'h37, 8'h00);
    rd(8'h42, 8'hfe);
    end_test("unmapped");
    // reset in mid-run restores every written byte and the trim, manual holdover and pull range values
    @(negedge core_clk);
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    cmp_out(19'(crystalTrim), 19'h09999);
    cmp_out(manualHoldValue, 19'h00000);
    cmp_out(19'(pull_range_value), 19'h00076);
    for (int i = 0; i < 11; i++)
      rd(8'h38 + 8'(i), rstImg[i]);
    end_test("reset again");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
